// ---- design/afe_params.svh ----
`ifndef AFE_PARAMS_SVH
`define AFE_PARAMS_SVH
// register indices; byte address is index times four
`define IDX_ROUTING 8'h2f
`define IDX_OSC_OVR 8'h40
`define IDX_OSC_PER 8'h41
`define IDX_CGAIN_OVR 8'h42
`define IDX_FGAIN_OVR 8'h43
`define IDX_GAIN_PER 8'h44
`define IDX_COFS_OVR 8'h45
`define IDX_OFS_PER 8'h47
// field positions
`define FORCE_BIT 15
`define ROUTE_BIT 0
`define GAIN_MSB 5
`define CODE_MSB 7
`define MULT_LSB 6
// reset values
`define REG_RESET 16'h0000
`define CODE_RESET 8'h00
// timing: one period unit is 2 us
`define UNIT_NS 2000
`define CLK_NS 10
`define UNIT_CYCLES (`UNIT_NS / `CLK_NS)
`endif

// ---- design/afe_pkg.sv ----
`default_nettype none
package afe_pkg;
  typedef logic [15:0] reg16_t;
  typedef logic [7:0] code8_t;
  typedef logic [5:0] code6_t;
endpackage
`default_nettype wire

// ---- design/afe_pacer.sv ----
`include "afe_params.svh"
`default_nettype none
// periodic update tick: one pulse every period times unit cycles
module afe_pacer
  import afe_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] period,
  output logic tick
);
  localparam int UW = 8;
  localparam logic [UW-1:0] UNIT_LAST = UW'(`UNIT_CYCLES - 1);
  logic [UW-1:0] unit_q;
  logic [15:0] count_q;
  logic [UW-1:0] unit_d;
  logic [15:0] count_d;
  logic unit_end;
  logic period_end;
  logic tick_d;
  assign unit_end = (unit_q == UNIT_LAST);
  assign period_end = unit_end && (count_q >= period - 16'h0001);
  // zero period: counters held at zero, no tick
  assign unit_d = (period == 16'h0000 || unit_end) ? '0 : unit_q + 1'b1;
  assign count_d = (period == 16'h0000 || period_end) ? 16'h0000 :
                   (unit_end ? count_q + 16'h0001 : count_q);
  assign tick_d = (period != 16'h0000) && period_end;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      unit_q <= '0;
      count_q <= 16'h0000;
      tick <= 1'b0;
    end
    else
    begin
      unit_q <= unit_d;
      count_q <= count_d;
      tick <= tick_d;
    end
  end
endmodule
`default_nettype wire

// ---- design/afe_gain_offset_regs.sv ----
// How it works
// - routing bit 0 set sends inputs 0-3 to fine, 4-7 to coarse; else swapped
// - osc force bit 15 applies code 7:0 and halts automatic drive updates
// - drive code: bits 7:6 power-of-two multiplier, bits 5:0 sixty-fourths over three
// - automatic drive code updates once per period of value times 200 cycles
// - zero drive period stops automatic drive updates
// - coarse gain force bit 15 applies code 5:0, halts coarse auto gain
// - fine gain force bit 15 applies code 5:0, halts fine auto gain
// - one shared gain period paces coarse and fine gain updates
// - zero gain period stops both gain controllers
// - coarse offset force bit 15 applies code 7:0, halts coarse auto offset
// - coarse offset code is signed two's complement, 250 uV per step
// - offset period paces coarse offset updates only; zero stops them
`include "afe_params.svh"
`default_nettype none
module afe_gain_offset_regs
  import afe_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] AUTO_OSC_CODE,
  input wire logic [5:0] AUTO_COARSE_GAIN,
  input wire logic [5:0] AUTO_FINE_GAIN,
  input wire logic [7:0] AUTO_COARSE_OFFSET,
  output logic FINE_RX_GROUP_SELECT,
  output logic [7:0] OSC_DRIVE_CODE,
  output logic [1:0] OSC_DRIVE_MULT,
  output logic [5:0] OSC_DRIVE_FRAC,
  output logic [5:0] COARSE_GAIN_CODE,
  output logic [5:0] FINE_GAIN_CODE,
  output logic [7:0] COARSE_OFFSET_CODE,
  output logic [7:0] RX_TO_FINE
);
  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic route_q;
  logic osc_en_q;
  code8_t osc_code_q;
  reg16_t osc_per_q;
  logic cg_en_q;
  code6_t cg_code_q;
  logic fg_en_q;
  code6_t fg_code_q;
  reg16_t gain_per_q;
  logic co_en_q;
  code8_t co_code_q;
  reg16_t ofs_per_q;
  // auto inputs come from another domain, two-flop sync
  code8_t osc_s1_q, osc_s2_q, co_s1_q, co_s2_q;
  code6_t cg_s1_q, cg_s2_q, fg_s1_q, fg_s2_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic [9:0] word;
  logic acc;
  logic wr;
  logic hit;
  logic sel_route, sel_osc, sel_osc_per, sel_cg, sel_fg, sel_gper, sel_co, sel_oper;
  assign word = PADDR[11:2];
  assign acc = PSEL && PENABLE;
  assign wr = acc && PWRITE && (PADDR[1:0] == 2'b00);
  assign sel_route = (word == 10'(`IDX_ROUTING));
  assign sel_osc = (word == 10'(`IDX_OSC_OVR));
  assign sel_osc_per = (word == 10'(`IDX_OSC_PER));
  assign sel_cg = (word == 10'(`IDX_CGAIN_OVR));
  assign sel_fg = (word == 10'(`IDX_FGAIN_OVR));
  assign sel_gper = (word == 10'(`IDX_GAIN_PER));
  assign sel_co = (word == 10'(`IDX_COFS_OVR));
  assign sel_oper = (word == 10'(`IDX_OFS_PER));
  assign hit = (PADDR[1:0] == 2'b00) && (sel_route || sel_osc || sel_osc_per || sel_cg ||
               sel_fg || sel_gper || sel_co || sel_oper);

  // read mux; reserved bits return zero
  // reserved read zero
  logic [15:0] rd_val;
  assign rd_val = sel_route ? {15'h0000, route_q} :
                  sel_osc ? {osc_en_q, 7'h00, osc_code_q} :
                  sel_osc_per ? osc_per_q :
                  sel_cg ? {cg_en_q, 9'h000, cg_code_q} :
                  sel_fg ? {fg_en_q, 9'h000, fg_code_q} :
                  sel_gper ? gain_per_q :
                  sel_co ? {co_en_q, 7'h00, co_code_q} :
                  sel_oper ? ofs_per_q : 16'h0000;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // one short block per register; only the named field bits are stored
  // reserved writes dropped
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      route_q <= 1'b0;
    end
    else if (wr && sel_route)
    begin
      route_q <= PWDATA[`ROUTE_BIT];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      osc_en_q <= 1'b0;
      osc_code_q <= `CODE_RESET;
    end
    else if (wr && sel_osc)
    begin
      osc_en_q <= PWDATA[`FORCE_BIT];
      osc_code_q <= PWDATA[`CODE_MSB:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      osc_per_q <= `REG_RESET;
    end
    else if (wr && sel_osc_per)
    begin
      osc_per_q <= PWDATA[`FORCE_BIT:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      cg_en_q <= 1'b0;
      cg_code_q <= 6'h00;
    end
    else if (wr && sel_cg)
    begin
      cg_en_q <= PWDATA[`FORCE_BIT];
      cg_code_q <= PWDATA[`GAIN_MSB:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      fg_en_q <= 1'b0;
      fg_code_q <= 6'h00;
    end
    else if (wr && sel_fg)
    begin
      fg_en_q <= PWDATA[`FORCE_BIT];
      fg_code_q <= PWDATA[`GAIN_MSB:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      gain_per_q <= `REG_RESET;
    end
    else if (wr && sel_gper)
    begin
      gain_per_q <= PWDATA[`FORCE_BIT:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      co_en_q <= 1'b0;
      co_code_q <= `CODE_RESET;
    end
    else if (wr && sel_co)
    begin
      co_en_q <= PWDATA[`FORCE_BIT];
      co_code_q <= PWDATA[`CODE_MSB:0];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      ofs_per_q <= `REG_RESET;
    end
    else if (wr && sel_oper)
    begin
      ofs_per_q <= PWDATA[`FORCE_BIT:0];
    end
  end

  // zero wait state slave; unmapped or misaligned gets pslverr
  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !hit;
      PRDATA <= (PSEL && !PENABLE && !PWRITE) ? {16'h0000, rd_val} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // update pacing
  // ----------------------------------------------------------------
  logic osc_tick, gain_tick, ofs_tick;
  afe_pacer u_osc_pacer (.clk(REF_CLK), .rst(RST), .period(osc_per_q), .tick(osc_tick));
  afe_pacer u_gain_pacer (.clk(REF_CLK), .rst(RST), .period(gain_per_q), .tick(gain_tick));
  afe_pacer u_ofs_pacer (.clk(REF_CLK), .rst(RST), .period(ofs_per_q), .tick(ofs_tick));

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      {osc_s1_q, osc_s2_q, co_s1_q, co_s2_q} <= 32'h0000_0000;
      {cg_s1_q, cg_s2_q, fg_s1_q, fg_s2_q} <= 24'h00_0000;
    end
    else
    begin
      osc_s1_q <= AUTO_OSC_CODE;
      osc_s2_q <= osc_s1_q;
      co_s1_q <= AUTO_COARSE_OFFSET;
      co_s2_q <= co_s1_q;
      cg_s1_q <= AUTO_COARSE_GAIN;
      cg_s2_q <= cg_s1_q;
      fg_s1_q <= AUTO_FINE_GAIN;
      fg_s2_q <= fg_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // dac code selection
  // ----------------------------------------------------------------
  // force wins; zero period means no tick; resume on tick
  code8_t osc_d;
  assign osc_d = osc_en_q ? osc_code_q : (osc_tick ? osc_s2_q : OSC_DRIVE_CODE);
  // coarse gain force; no tick at zero period
  code6_t cg_d;
  assign cg_d = cg_en_q ? cg_code_q : (gain_tick ? cg_s2_q : COARSE_GAIN_CODE);
  code6_t fg_d;
  assign fg_d = fg_en_q ? fg_code_q : (gain_tick ? fg_s2_q : FINE_GAIN_CODE);
  // coarse offset force; code passed as signed byte, unchanged
  code8_t co_d;
  assign co_d = co_en_q ? co_code_q : (ofs_tick ? co_s2_q : COARSE_OFFSET_CODE);
  logic [7:0] route_d;
  assign route_d = route_q ? 8'h0f : 8'hf0;

  always_ff @(posedge REF_CLK or posedge RST)
  begin
    if (RST)
    begin
      FINE_RX_GROUP_SELECT <= 1'b0;
      RX_TO_FINE <= 8'hf0;
      OSC_DRIVE_CODE <= `CODE_RESET;
      OSC_DRIVE_MULT <= 2'b00;
      OSC_DRIVE_FRAC <= 6'h00;
      COARSE_GAIN_CODE <= 6'h00;
      FINE_GAIN_CODE <= 6'h00;
      COARSE_OFFSET_CODE <= `CODE_RESET;
    end
    else
    begin
      FINE_RX_GROUP_SELECT <= route_q;
      RX_TO_FINE <= route_d;
      OSC_DRIVE_CODE <= osc_d;
      OSC_DRIVE_MULT <= osc_d[`CODE_MSB:`MULT_LSB];
      OSC_DRIVE_FRAC <= osc_d[`GAIN_MSB:0];
      COARSE_GAIN_CODE <= cg_d;
      FINE_GAIN_CODE <= fg_d;
      COARSE_OFFSET_CODE <= co_d;
    end
  end
endmodule
`default_nettype wire

// ---- test/afe_auto_model.sv ----
`default_nettype none
module afe_auto_model
  import afe_pkg::*;
(
  input wire logic sel,
  output logic [7:0] osc,
  output logic [5:0] cgain,
  output logic [5:0] fgain,
  output logic [7:0] cofs
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // automatic codes
  // ----
  // codes move only when sel flips, so each update can be traced
  assign osc = sel ? 8'h9e : 8'h11;
  assign cgain = sel ? 6'h0b : 6'h07;
  assign fgain = sel ? 6'h14 : 6'h02;
  assign cofs = sel ? 8'hf6 : 8'h1c;
endmodule
`default_nettype wire

// ---- test/afe_regs_props.sv ----
`default_nettype none
module afe_regs_props
  import afe_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic FINE_RX_GROUP_SELECT,
  input wire logic [7:0] OSC_DRIVE_CODE,
  input wire logic [1:0] OSC_DRIVE_MULT,
  input wire logic [5:0] OSC_DRIVE_FRAC,
  input wire logic [5:0] COARSE_GAIN_CODE,
  input wire logic [5:0] FINE_GAIN_CODE,
  input wire logic [7:0] COARSE_OFFSET_CODE,
  input wire logic [7:0] RX_TO_FINE
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // properties
  // ----
  wire logic wr = PSEL & PENABLE & PREADY & PWRITE;
  wire logic frc = wr & PWDATA[15];
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  a_route_map: assert property (RX_TO_FINE == (FINE_RX_GROUP_SELECT ? 8'h0f : 8'hf0))
    else $error("route map");
  a_route_wr: assert property (wr && PADDR == 12'h0bc
    |-> ##2 FINE_RX_GROUP_SELECT == $past(PWDATA[0], 2)) else $error("route write");
  a_drive_fields: assert property ({OSC_DRIVE_MULT, OSC_DRIVE_FRAC} == OSC_DRIVE_CODE)
    else $error("drive fields");
  a_osc_force: assert property (frc && PADDR == 12'h100
    |-> ##2 OSC_DRIVE_CODE == $past(PWDATA[7:0], 2)) else $error("osc force");
  a_cgain_force: assert property (frc && PADDR == 12'h108
    |-> ##2 COARSE_GAIN_CODE == $past(PWDATA[5:0], 2)) else $error("coarse gain force");
  a_fgain_force: assert property (frc && PADDR == 12'h10c
    |-> ##2 FINE_GAIN_CODE == $past(PWDATA[5:0], 2)) else $error("fine gain force");
  a_cofs_force: assert property (frc && PADDR == 12'h114
    |-> ##2 COARSE_OFFSET_CODE == $past(PWDATA[7:0], 2)) else $error("offset force");
  a_resv_zero: assert property (PSEL && PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0000)
    else $error("upper read bits");
endmodule
bind afe_gain_offset_regs afe_regs_props props (.*);
`default_nettype wire

// ---- test/testbench.sv ----
`include "afe_params.svh"
`default_nettype none
module testbench
  import afe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] i; logic [15:0] m;} row_t;
  row_t rows[8] = '{'{`IDX_ROUTING, 16'h0001}, '{`IDX_OSC_OVR, 16'h80ff},
    '{`IDX_OSC_PER, 16'hffff}, '{`IDX_CGAIN_OVR, 16'h803f}, '{`IDX_FGAIN_OVR, 16'h803f},
    '{`IDX_GAIN_PER, 16'hffff}, '{`IDX_COFS_OVR, 16'h80ff}, '{`IDX_OFS_PER, 16'hffff}};
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, sel = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pw = 32'h0000_0000, rd, prdata;
  logic err, pready, pslverr, frs;
  logic [7:0] osc, cofs, rxf, a_osc, a_cofs;
  logic [5:0] frac, cg, fg, a_cg, a_fg;
  logic [1:0] mult;
  int mismatches = 0, check_count = 0, cyc = 0, t0;
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  afe_auto_model model (.sel(sel), .osc(a_osc), .cgain(a_cg), .fgain(a_fg), .cofs(a_cofs));
  afe_gain_offset_regs DUT (.REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pw), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .AUTO_OSC_CODE(a_osc), .AUTO_COARSE_GAIN(a_cg),
    .AUTO_FINE_GAIN(a_fg), .AUTO_COARSE_OFFSET(a_cofs), .FINE_RX_GROUP_SELECT(frs),
    .OSC_DRIVE_CODE(osc), .OSC_DRIVE_MULT(mult), .OSC_DRIVE_FRAC(frac),
    .COARSE_GAIN_CODE(cg), .FINE_GAIN_CODE(fg), .COARSE_OFFSET_CODE(cofs), .RX_TO_FINE(rxf));
  // ----
  // tasks
  // ----
  task summarize;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [11:0] adr(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  // request held until pready is seen high at a rising edge; read data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    {psel, pen, pwr, pa, pw} <= {2'b10, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
      mismatches++;
    rd = prdata;
    err = pslverr;
    {psel, pen} <= 2'b00;
  endtask
  task st;
    repeat (3) @(negedge clk);
  endtask
  task automatic wchg(input logic o);
    logic [7:0] v;
    int k;
    v = o ? osc : cofs;
    k = 0;
    while ((o ? osc : cofs) === v && k < 1000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 1000)
      mismatches++;
  endtask
  initial
  begin
    #300us;
    mismatches++;
    summarize;
  end
  // ----
  // sequence
  // ----
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    st;
    chk("rx_to_fine", 32'h0000_00f0, rxf);
    chk("route sel", 32'h0000_0000, frs);
    foreach (rows[i])
    begin
      apb(1'b0, adr(rows[i].i), 32'h0000_0000);
      chk("reset value", 32'h0000_0000, rd);
      apb(1'b1, adr(rows[i].i), 32'hffff_ff95);
      apb(1'b0, adr(rows[i].i), 32'h0000_0000);
      chk("readback", {16'h0000, rows[i].m & 16'hff95}, rd);
      apb(1'b1, adr(rows[i].i), 32'h0000_0000);
    end
    apb(1'b0, 12'h200, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, err);
    apb(1'b1, 12'h0bd, 32'h0000_0001);
    chk("misaligned", 32'h0000_0001, err);
    apb(1'b1, adr(`IDX_ROUTING), 32'h0000_0001);
    apb(1'b1, adr(`IDX_OSC_OVR), 32'h0000_80c5);
    apb(1'b1, adr(`IDX_CGAIN_OVR), 32'h0000_8016);
    apb(1'b1, adr(`IDX_FGAIN_OVR), 32'h0000_8005);
    apb(1'b1, adr(`IDX_COFS_OVR), 32'h0000_8080);
    st;
    chk("rx_to_fine", 32'h0000_000f, rxf);
    chk("route sel", 32'h0000_0001, frs);
    chk("osc", 32'h0000_00c5, osc);
    chk("mult", 32'h0000_0003, mult);
    chk("frac", 32'h0000_0005, frac);
    chk("cgain", 32'h0000_0016, cg);
    chk("fgain", 32'h0000_0005, fg);
    chk("cofs", 32'h0000_0080, cofs);
    foreach (rows[i])
      if (rows[i].m[15])
        apb(1'b1, adr(rows[i].i), 32'h0000_0000);
    repeat (500) @(negedge clk);
    chk("osc held", 32'h0000_00c5, osc);
    chk("gain held", 32'h0000_0156, {fg, cg});
    chk("cofs held", 32'h0000_0080, cofs);
    apb(1'b1, adr(`IDX_OSC_PER), 32'h0000_0001);
    st;
    wchg(1'b1);
    chk("osc auto", a_osc, osc);
    t0 = cyc;
    @(posedge clk);
    sel <= 1'b1;
    wchg(1'b1);
    chk("osc period", `UNIT_CYCLES, cyc - t0);
    apb(1'b1, adr(`IDX_GAIN_PER), 32'h0000_0001);
    repeat (`UNIT_CYCLES + 10) @(negedge clk);
    chk("gain auto", {a_fg, a_cg}, {fg, cg});
    apb(1'b1, adr(`IDX_OFS_PER), 32'h0000_0001);
    st;
    wchg(1'b0);
    chk("cofs auto", a_cofs, cofs);
    // mid-run reset: everything back to its idle values
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    st;
    chk("reset rx_to_fine", 32'h0000_00f0, rxf);
    chk("reset route sel", 32'h0000_0000, frs);
    apb(1'b0, adr(`IDX_OSC_PER), 32'h0000_0000);
    chk("reset osc period", 32'h0000_0000, rd);
    repeat (`UNIT_CYCLES + 10) @(negedge clk);
    chk("reset osc", 32'h0000_0000, osc);
    summarize;
  end
endmodule
`default_nettype wire
